// *** hw/tcpd_params.svh ***
// offsets, field positions, reset values and scales of the cc control bank
`ifndef TCPD_PARAMS_SVH
`define TCPD_PARAMS_SVH

`define TCPD_ADDR_ID        8'h01
`define TCPD_ADDR_SW0       8'h02
`define TCPD_ADDR_SW1       8'h03
`define TCPD_ADDR_MEAS      8'h04
`define TCPD_ADDR_RECEIVE_SLICER_THRESHOLD     8'h05
`define TCPD_ADDR_CTRL0     8'h06

`define TCPD_BIT_PU2        7
`define TCPD_BIT_PU1        6
`define TCPD_BIT_VC2        5
`define TCPD_BIT_VC1        4
`define TCPD_BIT_MON2       3
`define TCPD_BIT_MON1       2
`define TCPD_BIT_PD2        1
`define TCPD_BIT_PD1        0
`define TCPD_BIT_PROLE      7
`define TCPD_BIT_REV_HI     6
`define TCPD_BIT_REV_LO     5
`define TCPD_BIT_DROLE      4
`define TCPD_BIT_AUTOACK    2
`define TCPD_BIT_TX2        1
`define TCPD_BIT_TX1        0
`define TCPD_BIT_VBUS       6
`define TCPD_BIT_HYS_HI     7
`define TCPD_BIT_HYS_LO     6
`define TCPD_BIT_FLUSH      6

`define TCPD_RST_SW0        8'h03
`define TCPD_RST_SW1        8'h20
`define TCPD_RST_MEAS       8'h31
`define TCPD_RST_RECEIVE_SLICER_THRESHOLD      8'h60
`define TCPD_WMASK_SW1      8'hf7
`define TCPD_WMASK_MEAS     8'h7f
`define TCPD_REV_UNUSED     2'h3

`define TCPD_COMPARATOR_REFERENCE_CODE_LSB_MV    15'h02a
`define TCPD_VBUS_SCALE     15'h00a
`define TCPD_HYS_ADD_01     7'h05
`define TCPD_HYS_ADD_10     7'h0a
`define TCPD_HYS_ADD_11     7'h20

`endif

// *** hw/tcpd_pkg.sv ***
// types shared by the cc control bank modules
package tcpd_pkg;

	typedef logic [1:0]  tcpd_spec_rev_t;
	typedef logic [1:0]  tcpd_hys_t;
	typedef logic [5:0]  tcpd_code_t;
	typedef logic [6:0]  tcpd_thr_t;
	typedef logic [14:0] tcpd_mv_t;

	typedef struct packed {
		logic [7:0]     sw0;
		logic [7:0]     sw1;
		logic [7:0]     meas;
		logic [7:0]     receive_slicer_threshold;
		logic [7:0]     rdata;
		logic           flush;
		logic           gcrc_req;
		logic           gcrc_prole;
		tcpd_spec_rev_t gcrc_rev;
		logic           gcrc_drole;
		logic           drv_first;
		logic           drv_second;
		tcpd_thr_t      hi_thr;
		tcpd_mv_t       ref_mv;
	} tcpd_state_t;

endpackage

// *** hw/tcpd_thresholds.sv ***
// comparator reference and slicer threshold arithmetic
`timescale 1ns/1ps
`include "tcpd_params.svh"

module tcpd_thresholds (
	input  wire tcpd_pkg::tcpd_code_t comparator_reference_code_code,
	input  wire logic                 vbus_sel,
	input  wire tcpd_pkg::tcpd_code_t slicer_threshold_code_code,
	input  wire tcpd_pkg::tcpd_hys_t  hys_sel,
	output tcpd_pkg::tcpd_mv_t        ref_mv,
	output tcpd_pkg::tcpd_thr_t       high_thr
);
	import tcpd_pkg::*;

	tcpd_mv_t  step;
	tcpd_mv_t  base;
	tcpd_thr_t low;

	always_comb begin
		step = {9'h000, comparator_reference_code_code} + 15'h0001;
		base = 15'(step * `TCPD_COMPARATOR_REFERENCE_CODE_LSB_MV);
		ref_mv = vbus_sel ? 15'(base * `TCPD_VBUS_SCALE) : base;
		low = {1'b0, slicer_threshold_code_code};
		case (hys_sel)
			2'h0: high_thr = low;
			2'h1: high_thr = low + `TCPD_HYS_ADD_01;
			2'h2: high_thr = low + `TCPD_HYS_ADD_10;
			default: high_thr = low + `TCPD_HYS_ADD_11;
		endcase
	end

endmodule

// *** hw/tcpd_ackhdr.sv ***
// role and revision bits of an automatic goodcrc header
`timescale 1ns/1ps

module tcpd_ackhdr (
	input  wire logic                     rx_sop,
	input  wire logic                     power_role,
	input  wire logic                     data_role,
	input  wire tcpd_pkg::tcpd_spec_rev_t spec_rev,
	output logic                          hdr_power_role,
	output logic                          hdr_data_role,
	output tcpd_pkg::tcpd_spec_rev_t      hdr_spec_rev
);
	import tcpd_pkg::*;

	// role bits only carry port roles for sop; otherwise they stay low
	always_comb begin
		hdr_power_role = rx_sop & power_role;
		hdr_data_role = rx_sop & data_role;
		hdr_spec_rev = spec_rev;
	end

endmodule

// *** hw/tcpd_regs.sv ***
// cc termination, ack header and slicer control register bank
//
// Functional notes
// - pull-up enables per cc pin, reset off
// - vconn switch per cc pin, reset open
// - measurement routing per cc pin, reset off
// - sink pull-downs per cc pin, reset on
// - power role bit copied into goodcrc header for sop, reset sink
// - two-bit spec revision feeds goodcrc header, reset 01, 11 unused
// - data role bit copied into goodcrc header for sop, reset ufp
// - auto ack sends goodcrc after valid message when enabled, reset off
// - bmc driver reaches only enabled cc pins, reset off
// - lower slicer threshold equals slicer code
// - hysteresis adds 0, 5h, ah or 20h for upper threshold, reset 01
// - slicer code resets to 20h
// - writing one to flush empties transmit queue, self clears
// - read-only identification: version, product, revision fields
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "tcpd_params.svh"

module tcpd_regs #(
	// identification codes are arbitrary, not those of any real part
	parameter logic [3:0] chip_version_field  = 4'h5,
	parameter logic [1:0] chip_product_field  = 2'h2,
	parameter logic [1:0] chip_revision_field = 2'h3
) (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire logic [7:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	input  wire logic                 rx_msg_valid,
	input  wire logic                 rx_msg_sop,
	input  wire logic                 bmc_tx_active,
	output logic                      pullup_second_cc,
	output logic                      pullup_first_cc,
	output logic                      supply_switch_second_cc,
	output logic                      supply_switch_first_cc,
	output logic                      monitor_second_cc,
	output logic                      monitor_first_cc,
	output logic                      pulldown_second_cc,
	output logic                      pulldown_first_cc,
	output logic                      transmit_on_second_cc,
	output logic                      transmit_on_first_cc,
	output logic                      bmc_drive_second_cc,
	output logic                      bmc_drive_first_cc,
	output logic                      comparator_input_supply_sel,
	output tcpd_pkg::tcpd_code_t      comparator_reference_code,
	output tcpd_pkg::tcpd_mv_t        comparator_reference_mv,
	output tcpd_pkg::tcpd_code_t      slicer_threshold_code,
	output tcpd_pkg::tcpd_hys_t       slicer_hysteresis_sel,
	output tcpd_pkg::tcpd_thr_t       slicer_low_threshold,
	output tcpd_pkg::tcpd_thr_t       slicer_high_threshold,
	output logic                      transmit_queue_flush,
	output logic                      gcrc_request,
	output logic                      ack_power_role,
	output tcpd_pkg::tcpd_spec_rev_t  ack_spec_revision,
	output logic                      ack_data_role
);
	import tcpd_pkg::*;

	// arbitrary identification values, not tied to any real part
	localparam logic [7:0] id_value = {chip_version_field,
		chip_product_field, chip_revision_field};

	////////////////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state and helpers

	tcpd_state_t state;
	tcpd_state_t next_state;
	tcpd_mv_t    calc_ref_mv;
	tcpd_thr_t   calc_hi_thr;
	logic        hdr_prole;
	logic        hdr_drole;
	tcpd_spec_rev_t hdr_rev;
	logic        wr_sw0;
	logic        wr_sw1;
	logic        wr_meas;
	logic        wr_receive_slicer_threshold;
	logic        wr_ctrl0;

	tcpd_thresholds u_thresholds (
		.comparator_reference_code_code (state.meas[5:0]),
		.vbus_sel  (state.meas[`TCPD_BIT_VBUS]),
		.slicer_threshold_code_code (state.receive_slicer_threshold[5:0]),
		.hys_sel   (state.receive_slicer_threshold[`TCPD_BIT_HYS_HI:`TCPD_BIT_HYS_LO]),
		.ref_mv    (calc_ref_mv),
		.high_thr  (calc_hi_thr)
	);

	tcpd_ackhdr u_ackhdr (
		.rx_sop         (rx_msg_sop),
		.power_role     (state.sw1[`TCPD_BIT_PROLE]),
		.data_role      (state.sw1[`TCPD_BIT_DROLE]),
		.spec_rev       (state.sw1[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO]),
		.hdr_power_role (hdr_prole),
		.hdr_data_role  (hdr_drole),
		.hdr_spec_rev   (hdr_rev)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_state = state;
		wr_sw0 = reg_wr && (reg_addr == `TCPD_ADDR_SW0);
		wr_sw1 = reg_wr && (reg_addr == `TCPD_ADDR_SW1);
		wr_meas = reg_wr && (reg_addr == `TCPD_ADDR_MEAS);
		wr_receive_slicer_threshold = reg_wr && (reg_addr == `TCPD_ADDR_RECEIVE_SLICER_THRESHOLD);
		wr_ctrl0 = reg_wr && (reg_addr == `TCPD_ADDR_CTRL0);

		if (wr_sw0) begin
			next_state.sw0 = reg_wdata;
		end
		if (wr_sw1) begin
			next_state.sw1 = reg_wdata & `TCPD_WMASK_SW1;
			// the unused revision code leaves the field as it was
			if (reg_wdata[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO] ==
				`TCPD_REV_UNUSED) begin
				next_state.sw1[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO] =
					state.sw1[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO];
			end
		end
		if (wr_meas) begin
			next_state.meas = reg_wdata & `TCPD_WMASK_MEAS;
		end
		if (wr_receive_slicer_threshold) begin
			next_state.receive_slicer_threshold = reg_wdata;
		end

		// flush is a one-cycle pulse per write of one; the stored bit stays set only across back-to-back writes
		next_state.flush = wr_ctrl0 && reg_wdata[`TCPD_BIT_FLUSH];

		next_state.gcrc_req = rx_msg_valid &&
			state.sw1[`TCPD_BIT_AUTOACK];
		if (rx_msg_valid && state.sw1[`TCPD_BIT_AUTOACK]) begin
			next_state.gcrc_prole = hdr_prole;
			next_state.gcrc_drole = hdr_drole;
			next_state.gcrc_rev = hdr_rev;
		end

		next_state.drv_first = bmc_tx_active &&
			state.sw1[`TCPD_BIT_TX1];
		next_state.drv_second = bmc_tx_active &&
			state.sw1[`TCPD_BIT_TX2];

		next_state.hi_thr = calc_hi_thr;
		next_state.ref_mv = calc_ref_mv;

		next_state.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`TCPD_ADDR_ID: next_state.rdata = id_value;
				`TCPD_ADDR_SW0: next_state.rdata = state.sw0;
				`TCPD_ADDR_SW1: next_state.rdata = state.sw1;
				`TCPD_ADDR_MEAS: next_state.rdata = state.meas;
				`TCPD_ADDR_RECEIVE_SLICER_THRESHOLD: next_state.rdata = state.receive_slicer_threshold;
				default: next_state.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			state <= '{
				sw0: `TCPD_RST_SW0,
				sw1: `TCPD_RST_SW1,
				meas: `TCPD_RST_MEAS,
				receive_slicer_threshold: `TCPD_RST_RECEIVE_SLICER_THRESHOLD,
				default: '0
			};
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign reg_rdata = state.rdata;
	assign pullup_second_cc = state.sw0[`TCPD_BIT_PU2];
	assign pullup_first_cc = state.sw0[`TCPD_BIT_PU1];
	assign supply_switch_second_cc = state.sw0[`TCPD_BIT_VC2];
	assign supply_switch_first_cc = state.sw0[`TCPD_BIT_VC1];
	assign monitor_second_cc = state.sw0[`TCPD_BIT_MON2];
	assign monitor_first_cc = state.sw0[`TCPD_BIT_MON1];
	assign pulldown_second_cc = state.sw0[`TCPD_BIT_PD2];
	assign pulldown_first_cc = state.sw0[`TCPD_BIT_PD1];
	assign transmit_on_second_cc = state.sw1[`TCPD_BIT_TX2];
	assign transmit_on_first_cc = state.sw1[`TCPD_BIT_TX1];
	assign bmc_drive_second_cc = state.drv_second;
	assign bmc_drive_first_cc = state.drv_first;
	assign comparator_input_supply_sel = state.meas[`TCPD_BIT_VBUS];
	assign comparator_reference_code = state.meas[5:0];
	assign comparator_reference_mv = state.ref_mv;
	assign slicer_threshold_code = state.receive_slicer_threshold[5:0];
	assign slicer_hysteresis_sel =
		state.receive_slicer_threshold[`TCPD_BIT_HYS_HI:`TCPD_BIT_HYS_LO];
	assign slicer_low_threshold = {1'b0, state.receive_slicer_threshold[5:0]};
	assign slicer_high_threshold = state.hi_thr;
	assign transmit_queue_flush = state.flush;
	assign gcrc_request = state.gcrc_req;
	assign ack_power_role = state.gcrc_prole;
	assign ack_spec_revision = state.gcrc_rev;
	assign ack_data_role = state.gcrc_drole;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_sync);

	a_pullup_write: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_SW0 |=>
		{pullup_second_cc, pullup_first_cc} == $past(reg_wdata[7:6]))
		else $error("pull-up enables do not follow the write");

	a_vconn_monitor: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_SW0 |=>
		{supply_switch_second_cc, supply_switch_first_cc,
		 monitor_second_cc, monitor_first_cc} == $past(reg_wdata[5:2]))
		else $error("vconn or monitor switches do not follow the write");

	a_pulldown_hold: assert property (
		!(reg_wr && reg_addr == `TCPD_ADDR_SW0) |=>
		$stable({pulldown_second_cc, pulldown_first_cc}))
		else $error("pull-downs changed without a write");

	a_ack_pulse: assert property (
		rx_msg_valid && state.sw1[`TCPD_BIT_AUTOACK] |=>
		gcrc_request ##1 (!gcrc_request || $past(rx_msg_valid)))
		else $error("auto ack request missing or stretched");

	a_ack_off: assert property (
		!state.sw1[`TCPD_BIT_AUTOACK] |=> !gcrc_request)
		else $error("goodcrc requested while auto ack is off");

	a_ack_roles: assert property (
		gcrc_request |->
		ack_power_role ==
		($past(rx_msg_sop) && $past(state.sw1[`TCPD_BIT_PROLE])) &&
		ack_data_role ==
		($past(rx_msg_sop) && $past(state.sw1[`TCPD_BIT_DROLE])))
		else $error("ack header roles wrong");

	a_rev_unused: assert property (
		state.sw1[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO] != `TCPD_REV_UNUSED)
		else $error("unused spec revision code stored");

	a_tx_gate: assert property (
		bmc_drive_first_cc |-> $past(state.sw1[`TCPD_BIT_TX1]) &&
		$past(bmc_tx_active))
		else $error("bmc drives a disabled pin");

	a_ref_scale: assert property (
		##1 $stable(state.meas) |=>
		comparator_reference_mv ==
		15'(({9'h000, $past(state.meas[5:0], 2)} + 15'h0001) *
		`TCPD_COMPARATOR_REFERENCE_CODE_LSB_MV *
		($past(state.meas[`TCPD_BIT_VBUS]) ? `TCPD_VBUS_SCALE : 15'h1)))
		else $error("comparator reference wrong");

	a_receive_slicer_threshold_hys: assert property (
		state.receive_slicer_threshold[`TCPD_BIT_HYS_HI:`TCPD_BIT_HYS_LO] == 2'h3 |=>
		slicer_high_threshold ==
		$past(slicer_low_threshold) + `TCPD_HYS_ADD_11)
		else $error("slicer hysteresis wrong");

	a_flush_pulse: assert property (
		transmit_queue_flush |-> ($past(reg_wr) &&
		$past(reg_addr) == `TCPD_ADDR_CTRL0 && $past(reg_wdata[6]))
		##1 (!transmit_queue_flush || $past(reg_wr)))
		else $error("flush pulse without a write of one");

	a_id_read: assert property (
		reg_rd && reg_addr == `TCPD_ADDR_ID |=> reg_rdata == id_value)
		else $error("identification read wrong");

	a_pulldown_write: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_SW0 |=>
		{pulldown_second_cc, pulldown_first_cc} == $past(reg_wdata[1:0]))
		else $error("pull-downs do not follow the write");

	a_pullup_hold: assert property (
		!(reg_wr && reg_addr == `TCPD_ADDR_SW0) |=>
		$stable({pullup_second_cc, pullup_first_cc}))
		else $error("pull-ups changed without a write");

	a_monitor_hold: assert property (
		!(reg_wr && reg_addr == `TCPD_ADDR_SW0) |=>
		$stable({monitor_second_cc, monitor_first_cc}))
		else $error("monitor routing changed without a write");

	a_ack_rev: assert property (
		gcrc_request |-> ack_spec_revision ==
		$past(state.sw1[`TCPD_BIT_REV_HI:`TCPD_BIT_REV_LO]))
		else $error("ack header revision wrong");

	a_ack_hold: assert property (
		!gcrc_request |->
		$stable({ack_power_role, ack_spec_revision, ack_data_role}))
		else $error("ack header changed without a request");

	a_tx_second: assert property (
		bmc_drive_second_cc |-> $past(state.sw1[`TCPD_BIT_TX2]) &&
		$past(bmc_tx_active))
		else $error("bmc drives a disabled second pin");

	a_tx_follow: assert property (
		bmc_tx_active && transmit_on_first_cc |=> bmc_drive_first_cc)
		else $error("bmc driver missing on an enabled pin");

	a_meas_write: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_MEAS |=>
		{comparator_input_supply_sel, comparator_reference_code} ==
		$past(reg_wdata[6:0]))
		else $error("comparator selection does not follow the write");

	a_receive_slicer_threshold_write: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_RECEIVE_SLICER_THRESHOLD |=>
		{slicer_hysteresis_sel, slicer_threshold_code} == $past(reg_wdata))
		else $error("slicer fields do not follow the write");

	a_low_thr: assert property (
		reg_wr && reg_addr == `TCPD_ADDR_RECEIVE_SLICER_THRESHOLD |=>
		slicer_low_threshold == {1'b0, $past(reg_wdata[5:0])})
		else $error("lower slicer threshold wrong");

	a_flush_idle: assert property (
		!(reg_wr && reg_addr == `TCPD_ADDR_CTRL0) |=>
		!transmit_queue_flush)
		else $error("flush pulse without a control write");

endmodule

// *** tb/tcpd_port_partner.sv ***
// behavioural port partner: received messages and transmit demand
`timescale 1ns/1ps

module tcpd_port_partner (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic send,
	input  wire logic send_sop,
	input  wire logic want_tx,
	output logic      rx_msg_valid,
	output logic      rx_msg_sop,
	output logic      bmc_tx_active
);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_msg_valid <= 1'b0;
			rx_msg_sop <= 1'b0;
			bmc_tx_active <= 1'b0;
		end else begin
			rx_msg_valid <= send;
			// type line carries no meaning outside a message
			rx_msg_sop <= send ? send_sop : ~rx_msg_sop;
			bmc_tx_active <= want_tx;
		end
	end
endmodule

// *** tb/tb_typec_pd_cc_control_regs.sv ***
// self-checking bench for the cc control register bank
`timescale 1ns/1ps

module tb_typec_pd_cc_control_regs;
	import tcpd_pkg::*;
	// identification values are arbitrary
	localparam logic [3:0] ver  = 4'h6;
	localparam logic [1:0] prod = 2'h2;
	localparam logic [1:0] rev  = 2'h3;

	logic           clock, nrst, reg_wr, reg_rd, send, send_sop, want_tx;
	logic [7:0]     reg_addr, reg_wdata, reg_rdata;
	logic           rx_msg_valid, rx_msg_sop, bmc_tx_active;
	logic           pullup_second_cc, pullup_first_cc;
	logic           supply_switch_second_cc, supply_switch_first_cc;
	logic           monitor_second_cc, monitor_first_cc;
	logic           pulldown_second_cc, pulldown_first_cc;
	logic           transmit_on_second_cc, transmit_on_first_cc;
	logic           bmc_drive_second_cc, bmc_drive_first_cc;
	logic           comparator_input_supply_sel, transmit_queue_flush;
	logic           gcrc_request, ack_power_role, ack_data_role;
	tcpd_code_t     comparator_reference_code, slicer_threshold_code;
	tcpd_mv_t       comparator_reference_mv;
	tcpd_hys_t      slicer_hysteresis_sel;
	tcpd_thr_t      slicer_low_threshold, slicer_high_threshold;
	tcpd_spec_rev_t ack_spec_revision;
	int             m[8];
	int             bad_count, n_tests, cycles, seed, i, d;

	tcpd_regs #(
		.chip_version_field  (ver),
		.chip_product_field  (prod),
		.chip_revision_field (rev)
	) i_tcpd_regs (
		.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_msg_valid, .rx_msg_sop, .bmc_tx_active,
		.pullup_second_cc, .pullup_first_cc,
		.supply_switch_second_cc, .supply_switch_first_cc,
		.monitor_second_cc, .monitor_first_cc,
		.pulldown_second_cc, .pulldown_first_cc,
		.transmit_on_second_cc, .transmit_on_first_cc,
		.bmc_drive_second_cc, .bmc_drive_first_cc,
		.comparator_input_supply_sel, .comparator_reference_code,
		.comparator_reference_mv, .slicer_threshold_code,
		.slicer_hysteresis_sel, .slicer_low_threshold,
		.slicer_high_threshold, .transmit_queue_flush, .gcrc_request,
		.ack_power_role, .ack_spec_revision, .ack_data_role
	);

	tcpd_port_partner i_tcpd_port_partner (
		.clock, .nrst, .send, .send_sop, .want_tx,
		.rx_msg_valid, .rx_msg_sop, .bmc_tx_active
	);

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			finish_test();
		end
	end

	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// bus write, with the model updated as the bank should be
	task automatic wr(int a, int v);
		@(posedge clock);
		reg_addr <= 8'(a);
		reg_wdata <= 8'(v);
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		if (a == 2 || a == 5) m[a] = v & 8'hff;
		if (a == 4) m[4] = v & 8'h7f;
		if (a == 3 && ((v >> 5) & 3) == 3) m[3] = (m[3] & 8'h60) | (v & 8'h97);
		else if (a == 3) m[3] = v & 8'hf7;
	endtask

	task automatic rd(int a);
		int e;
		e = (a == 1) ? {ver, prod, rev} : (a >= 2 && a <= 5) ? m[a] : 0;
		@(posedge clock);
		reg_addr <= 8'(a);
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk("read data", 16'(reg_rdata), 16'(e));
	endtask

	task automatic check_outs();
		int c, s, h;
		repeat (2) @(posedge clock);
		#1;
		c = m[4] & 8'h3f;
		s = m[5] & 8'h3f;
		h = m[5] >> 6;
		h = (h == 0) ? 0 : (h == 1) ? 5 : (h == 2) ? 10 : 32;
		chk("cc switches", 16'({pullup_second_cc, pullup_first_cc,
			supply_switch_second_cc, supply_switch_first_cc,
			monitor_second_cc, monitor_first_cc, pulldown_second_cc,
			pulldown_first_cc}), 16'(m[2]));
		chk("tx pins", 16'({transmit_on_second_cc, transmit_on_first_cc}),
			16'(m[3] & 3));
		chk("supply sel", 16'(comparator_input_supply_sel),
			16'(m[4] >> 6));
		chk("ref code", 16'(comparator_reference_code), 16'(c));
		chk("ref mv", 16'(comparator_reference_mv),
			16'((c + 1) * 42 * ((m[4] >> 6) ? 10 : 1)));
		chk("slicer code", 16'(slicer_threshold_code), 16'(s));
		chk("slicer hys", 16'(slicer_hysteresis_sel), 16'(m[5] >> 6));
		chk("low thr", 16'(slicer_low_threshold), 16'(s));
		chk("high thr", 16'(slicer_high_threshold), 16'(s + h));
	endtask

	// received message from the partner, then the acknowledge header
	task automatic ack(int v, int sop);
		int en;
		wr(3, v);
		en = (m[3] >> 2) & 1;
		@(posedge clock);
		send <= 1'b1;
		send_sop <= 1'(sop);
		@(posedge clock);
		send <= 1'b0;
		@(posedge clock);
		#1;
		chk("ack request", 16'(gcrc_request), 16'(en));
		if (en == 1) begin
			chk("ack power", 16'(ack_power_role), 16'(sop & (m[3] >> 7)));
			chk("ack rev", 16'(ack_spec_revision), 16'((m[3] >> 5) & 3));
			chk("ack data", 16'(ack_data_role), 16'(sop & (m[3] >> 4)));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 20;
		bad_count = 0;
		n_tests = 0;
		cycles = 0;
		nrst = 1'b0;
		{reg_wr, reg_rd, send, send_sop, want_tx} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		m = '{0, 0, 8'h03, 8'h20, 8'h31, 8'h60, 0, 0};
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (3) @(posedge clock);
		check_outs();
		for (i = 0; i < 8; i++) rd(i);
		wr(1, 8'hff);
		rd(1);
		wr(3, 8'h60);
		rd(3);
		$display("test reset and identification done");
		wr(6, 8'h40);
		#1;
		chk("flush", 16'(transmit_queue_flush), 16'h0001);
		@(posedge clock);
		#1;
		chk("flush clear", 16'(transmit_queue_flush), 16'h0000);
		wr(6, 8'hbf);
		#1;
		chk("no flush", 16'(transmit_queue_flush), 16'h0000);
		$display("test flush done");
		for (i = 0; i < 4; i++) begin
			wr(5, (i << 6) | 8'h3f);
			check_outs();
		end
		wr(4, 8'hff);
		check_outs();
		wr(4, 8'h00);
		check_outs();
		for (i = 0; i < 40; i++) begin
			d = $random(seed) & 7;
			wr(d, $random(seed));
			check_outs();
			rd(d);
		end
		$display("test thresholds and random writes done");
		for (i = 0; i < 8; i++) begin
			ack(($random(seed) & 8'hfb) | (((i >> 1) & 1) << 2), i & 1);
		end
		$display("test auto acknowledge done");
		for (i = 0; i < 4; i++) begin
			wr(3, (m[3] & 8'hfc) | i);
			@(posedge clock);
			want_tx <= 1'b1;
			repeat (3) @(posedge clock);
			#1;
			chk("bmc drive", 16'({bmc_drive_second_cc, bmc_drive_first_cc}),
				16'(i));
			@(posedge clock);
			want_tx <= 1'b0;
			repeat (3) @(posedge clock);
			#1;
			chk("bmc idle", 16'({bmc_drive_second_cc, bmc_drive_first_cc}),
				16'h0000);
		end
		$display("test transmit pins done");
		finish_test();
	end
endmodule
